// file: design/msd_map.vh
// Constants for the speed-command front end: timing, thresholds, registers.
`ifndef MSD_MAP_VH
`define MSD_MAP_VH

// Clock rate in kHz and Hz.
`define MSD_CLK_KHZ 10000
`define MSD_CLK_HZ 10000000

// Probe timing in milliseconds.
`define MSD_PROBE_START_MS 270
`define MSD_PROBE_PHASE_MS 40

// The same probe times in clock cycles: 270 ms and 40 ms at 10 MHz.
`define MSD_PROBE_START_CYC 23'h29_32E0
`define MSD_PROBE_PHASE_CYC 23'h06_1A80

// Set-value thresholds in millivolts.
`define MSD_SV_OFF_MV 14'h00AA
`define MSD_SV_LIN_MV 14'h014A
`define MSD_SV_MAX_MV 14'h2A30
`define MSD_PROBE_MV 14'h09C4

// Speed figures in rpm; 600 rpm/V is 0.6 rpm/mV as a 16-bit fraction.
`define MSD_RPM_MIN 13'h00C8
`define MSD_SCALE_FRAC 16'h999A
`define MSD_SCALE_SHIFT 16

// Acceleration limits in rpm per second.
`define MSD_ACCEL_FAST 6000
`define MSD_ACCEL_SLOW 3000

// Limiter step intervals in cycles per rpm: 1666 fast, 3333 slow.
`define MSD_STEP_FAST 12'h682
`define MSD_STEP_SLOW 12'hD05

// Six pulses per turn: toggle whenever the rpm sum reaches 5e7.
`define MSD_PULSE_HALF 26'h2FA_F080

// Averaging shift of the set-value filter.
`define MSD_FILT_SHIFT 16

// Register byte offsets.
`define MSD_OFS_CTRL 8'h00
`define MSD_OFS_STATUS 8'h04
`define MSD_OFS_SETVAL 8'h08
`define MSD_OFS_SPEED 8'h0C
`define MSD_OFS_ACTUAL 8'h10

// Control fields and reset value.
`define MSD_CTRL_DIRV 0
`define MSD_CTRL_FAST 1
`define MSD_CTRL_RST 2'h2

// Status fields.
`define MSD_ST_DONE 0
`define MSD_ST_TWOW 1
`define MSD_ST_PWR 2
`define MSD_ST_CW 3
`define MSD_ST_PEND 4

`endif

// file: design/msd_sv_filter.v
// Running average of the digitised set value, used for PWM set values.
`timescale 1ns/10ps
`include "msd_map.vh"
module msd_sv_filter
(
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire [13:0] i_sample,
  output wire [13:0] o_avg
);

  // Accumulator holds the average scaled up by the filter shift.
  reg  [29:0] acc;
  // Sample widened to the accumulator width.
  wire [29:0] wide = {i_sample, 16'h0000};

  // First-order low pass; the time constant of about 6.5 ms spans many
  // periods of the slowest PWM source while still settling in one probe
  // phase.
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      acc <= 30'h0000_0000;
    end
    else
    begin
      acc <= acc + (wide >> `MSD_FILT_SHIFT) - (acc >> `MSD_FILT_SHIFT);
    end
  end

  assign o_avg = acc[29:16];

endmodule

// file: design/msd_ramp.v
// Acceleration limiter that walks the speed command toward its target.
`timescale 1ns/10ps
`include "msd_map.vh"
module msd_ramp
(
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire [12:0] i_target,
  input  wire [11:0] i_step_cyc,
  input  wire        i_load,
  input  wire [12:0] i_load_val,
  output reg  [12:0] o_cmd
);

  // Cycles since the last one-rpm step.
  reg [11:0] tick;

  // One rpm per step interval; while loaded the command tracks the real
  // speed so that a restart ramps from where the rotor actually is.
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      tick  <= 12'h000;
      o_cmd <= 13'h0000;
    end
    else if (i_load)
    begin
      tick  <= 12'h000;
      o_cmd <= i_load_val;
    end
    else if (tick >= i_step_cyc - 12'h001)
    begin
      tick <= 12'h000;
      if (o_cmd < i_target)
      begin
        o_cmd <= o_cmd + 13'h0001;
      end
      else if (o_cmd > i_target)
      begin
        o_cmd <= o_cmd - 13'h0001;
      end
    end
    else
    begin
      tick <= tick + 12'h001;
    end
  end

endmodule

// file: design/msd_top.v
// Speed-command front end: set-value decode, mode probe and APB registers.
// Notes on behaviour
// - Enable version: enable high and value above 0.17 V.
// - Direction version: run when value above 0.17 V.
// - 0.17 to 0.33 V runs at 200 rpm.
// - Above 0.33 V target is volts times 600.
// - Speed changes limited by maximum acceleration.
// - Pulse output high at 270 ms, low 40 ms later.
// - Two-wire only if input follows the probe.
// - Two-wire speed proportional to supply voltage.
// - Fixed or rising input never selects two-wire.
// - PWM set value taken as its average.
// - Two-wire direction version still reads direction.
// - Enable low disables stage, motor coasts.
// - Direction change: coast to minimum, then reverse.
// - Six 50 percent pulses per turn, also disabled.
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`include "msd_map.vh"
module msd_top
#(
  parameter [22:0] P_PROBE_START_CYC = `MSD_PROBE_START_CYC,
  parameter [22:0] P_PROBE_PHASE_CYC = `MSD_PROBE_PHASE_CYC
)
(
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [7:0]  i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  input  wire        i_enable_pin,
  input  wire        i_rotation_direction_select,
  input  wire [13:0] i_setval_mv,
  input  wire [14:0] i_supply_mv,
  input  wire [12:0] i_actual_rpm,
  output reg         o_speed_pulse,
  output reg         o_power_enable,
  output reg         o_run_cw,
  output wire [12:0] o_speed_cmd
);

  // Probe sequencer states.
  localparam [1:0] ST_WAIT = 2'h0;
  localparam [1:0] ST_HIGH = 2'h1;
  localparam [1:0] ST_LOW  = 2'h2;
  localparam [1:0] ST_DONE = 2'h3;

  // Step intervals of the acceleration limiter, in clock cycles.
  localparam [11:0] STEP_FAST = `MSD_STEP_FAST;
  localparam [11:0] STEP_SLOW = `MSD_STEP_SLOW;

  // Register index of an address; 7 marks an unmapped address.
  function [2:0] reg_index;
    input [7:0] addr;
    begin
      case (addr)
        `MSD_OFS_CTRL:   reg_index = 3'h0;
        `MSD_OFS_STATUS: reg_index = 3'h1;
        `MSD_OFS_SETVAL: reg_index = 3'h2;
        `MSD_OFS_SPEED:  reg_index = 3'h3;
        `MSD_OFS_ACTUAL: reg_index = 3'h4;
        default:         reg_index = 3'h7;
      endcase
    end
  endfunction

  reg  [1:0]  sync_a;      // First synchroniser stage of both pins.
  reg  [1:0]  sync_b;      // Second stage, the only one logic reads.
  reg  [1:0]  ctrl;        // Version and fast-variant control bits.
  reg  [1:0]  state;       // Probe sequencer state.
  reg  [22:0] cnt;         // Probe phase timer.
  reg         low1_above;  // Input level sampled before the probe.
  reg         high_above;  // Input level sampled while probing high.
  reg         two_wire;    // Latched operating mode.
  reg         dir_pend;    // Reversal waiting for the coast-down.
  reg  [25:0] pulse_acc;   // Phase sum of the speed pulse generator.
  reg  [12:0] next_target; // Speed target before the limiter.
  reg         next_permit; // Power stage permitted by inputs.
  wire [13:0] sv_avg;      // Averaged set value in millivolts.
  wire [13:0] sv_clip;     // Set value clipped at the top of the linear range only.
  wire [29:0] sv_prod;     // Set value times the 600 rpm/V scale.
  wire [25:0] pulse_sum;   // Phase sum after adding the present speed.
  wire        en_ok;       // Enable pin above its high threshold.
  wire        want_cw;     // Direction the inputs ask for.
  wire        sv_on;       // Set value above the disable threshold.
  wire [2:0]  wr_idx;      // Register hit by the present access.
  wire        acc_done;    // Access phase completes this edge.

  // Both pins come from outside; each passes two flip-flops first.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_sync
      always @(posedge i_clk)
      begin
        if (i_rst)
        begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end
        else
        begin
          sync_a[gi] <= (gi == 0) ? i_enable_pin
                                  : i_rotation_direction_select;
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  assign en_ok = sync_b[0];

  // The averaged value stands in for a PWM set value as well.
  msd_sv_filter u_filter
  (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_sample (i_setval_mv),
    .o_avg    (sv_avg)
  );

  assign sv_on   = sv_avg > `MSD_SV_OFF_MV;
  assign sv_clip = (sv_avg > `MSD_SV_MAX_MV) ? `MSD_SV_MAX_MV : sv_avg;
  assign sv_prod = {16'h0000, sv_clip} * {14'h0000, `MSD_SCALE_FRAC};

  // The enable version only turns one way; the direction version reads
  // the pin, in two-wire mode too.
  assign want_cw = ctrl[`MSD_CTRL_DIRV] ? sync_b[1] : 1'b1;

  // Probe sequencer. It drives the pulse pin low for 270 ms, high for
  // 40 ms, then low again for 40 ms, and samples the averaged input at the
  // end of each phase. The third sample stops a steadily rising input
  // from looking like a short. It runs once; only reset restarts it.
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state      <= ST_WAIT;
      cnt        <= 23'h00_0000;
      low1_above <= 1'b0;
      high_above <= 1'b0;
      two_wire   <= 1'b0;
    end
    else
    begin
      case (state)
        ST_WAIT:
        begin
          if (cnt == P_PROBE_START_CYC - 23'h00_0001)
          begin
            // Time to raise the probe.
            cnt        <= 23'h00_0000;
            low1_above <= sv_avg > `MSD_PROBE_MV;
            state      <= ST_HIGH;
          end
          else
          begin
            cnt <= cnt + 23'h00_0001;
          end
        end
        ST_HIGH:
        begin
          if (cnt == P_PROBE_PHASE_CYC - 23'h00_0001)
          begin
            // Probe released after its 40 ms.
            cnt        <= 23'h00_0000;
            high_above <= sv_avg > `MSD_PROBE_MV;
            state      <= ST_LOW;
          end
          else
          begin
            cnt <= cnt + 23'h00_0001;
          end
        end
        ST_LOW:
        begin
          if (cnt == P_PROBE_PHASE_CYC - 23'h00_0001)
          begin
            // Only low, high, low again counts as a short.
            two_wire <= ~low1_above & high_above &
                        ~(sv_avg > `MSD_PROBE_MV);
            cnt      <= 23'h00_0000;
            state    <= ST_DONE;
          end
          else
          begin
            cnt <= cnt + 23'h00_0001;
          end
        end
        ST_DONE:
        begin
          // Mode stays fixed until the next power-on.
          state <= ST_DONE;
        end
        default:
        begin
          state <= ST_WAIT;
        end
      endcase
    end
  end

  // Target speed and permission from the set value and the mode.
  always @*
  begin
    next_target = `MSD_RPM_MIN;
    next_permit = 1'b0;
    if (two_wire)
    begin
      // Supply in mV over 8 or 4 gives 125 or 250 rpm per volt.
      next_permit = 1'b1;
      if (ctrl[`MSD_CTRL_FAST])
      begin
        next_target = i_supply_mv[14:2];
      end
      else
      begin
        next_target = {1'b0, i_supply_mv[14:3]};
      end
    end
    else
    begin
      // Enable version needs the pin; the direction version does not.
      next_permit = sv_on & (ctrl[`MSD_CTRL_DIRV] | en_ok);
      if (sv_avg <= `MSD_SV_LIN_MV)
      begin
        next_target = `MSD_RPM_MIN;
      end
      else
      begin
        next_target = sv_prod[28:16];
      end
    end
  end

  // Power stage and direction. A reversal holds the stage off so the
  // rotor coasts down to minimum speed before turning the other way.
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_power_enable <= 1'b0;
      o_run_cw       <= 1'b1;
      dir_pend       <= 1'b0;
    end
    else
    begin
      if (state == ST_DONE && want_cw != o_run_cw)
      begin
        if (i_actual_rpm <= `MSD_RPM_MIN)
        begin
          o_run_cw <= want_cw;
          dir_pend <= 1'b0;
        end
        else
        begin
          dir_pend <= 1'b1;
        end
      end
      else
      begin
        dir_pend <= 1'b0;
      end
      // Nothing runs before the mode is known.
      o_power_enable <= (state == ST_DONE) & next_permit &
                        (want_cw == o_run_cw);
    end
  end

  // Command limited by acceleration; restarts from the real speed.
  msd_ramp u_ramp
  (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_target   (next_target),
    .i_step_cyc ((two_wire & ~ctrl[`MSD_CTRL_FAST]) ? STEP_SLOW : STEP_FAST),
    .i_load     (~o_power_enable),
    .i_load_val (i_actual_rpm),
    .o_cmd      (o_speed_cmd)
  );

  assign pulse_sum = pulse_acc + {13'h0000, i_actual_rpm};

  // Speed pulses: toggling every 5e7/rpm cycles gives rpm/10 Hz, six
  // pulses per turn at half duty, whatever the power stage does. During
  // the probe the sequencer owns the pin instead.
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pulse_acc     <= 26'h000_0000;
      o_speed_pulse <= 1'b0;
    end
    else if (state != ST_DONE)
    begin
      pulse_acc     <= 26'h000_0000;
      o_speed_pulse <= (state == ST_HIGH);
    end
    else if (pulse_sum >= `MSD_PULSE_HALF)
    begin
      pulse_acc     <= pulse_sum - `MSD_PULSE_HALF;
      o_speed_pulse <= ~o_speed_pulse;
    end
    else
    begin
      pulse_acc <= pulse_sum;
    end
  end

  assign wr_idx   = reg_index(i_paddr);
  assign acc_done = i_psel & i_penable & o_pready;

  // APB slave with one wait state: ready and data rise together on the
  // edge after the first access cycle, so every output is a flip-flop.
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      ctrl      <= `MSD_CTRL_RST;
    end
    else if (i_psel & i_penable & ~o_pready)
    begin
      o_pready  <= 1'b1;
      o_pslverr <= (wr_idx == 3'h7);
      case (reg_index(i_paddr))
        3'h0:    o_prdata <= {30'h0000_0000, ctrl};
        3'h1:    o_prdata <= {27'h000_0000, dir_pend, o_run_cw,
                              o_power_enable, two_wire,
                              state == ST_DONE};
        3'h2:    o_prdata <= {18'h0_0000, sv_avg};
        3'h3:    o_prdata <= {19'h0_0000, o_speed_cmd};
        3'h4:    o_prdata <= {19'h0_0000, i_actual_rpm};
        default: o_prdata <= 32'h0000_0000;
      endcase
    end
    else
    begin
      // Writes take effect only on the completing edge.
      if (acc_done & i_pwrite & (wr_idx == 3'h0))
      begin
        ctrl <= i_pwdata[1:0];
      end
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end
  end

endmodule

// file: dv/msd_sv_src.sv
// Set-value source model: a fixed-period PWM whose duty sets the average.
`timescale 1ns/10ps
module msd_sv_src
#(
  parameter int P_PERIOD = 10000
)
(
  input  wire         i_clk,
  input  wire  [13:0] i_amp_mv,
  input  wire  [6:0]  i_duty_pct,
  output logic [13:0] o_setval_mv
);
  int unsigned phase = 0; // Position inside the PWM period.

  // The period never changes; the amplitude and the duty follow their inputs.
  always @(posedge i_clk)
  begin
    phase <= (phase >= P_PERIOD - 1) ? 0 : phase + 1;
    if (phase * 100 < i_duty_pct * P_PERIOD)
      o_setval_mv <= i_amp_mv;
    else
      o_setval_mv <= 14'h0000;
  end
endmodule

// file: dv/msd_top_asserts.sv
// Checker for the speed-command front end, bound to its ports.
`timescale 1ns/10ps
module msd_top_asserts
#(
  parameter [22:0] P_PROBE_START_CYC = 23'h29_32E0,
  parameter [22:0] P_PROBE_PHASE_CYC = 23'h06_1A80
)
(
  input wire        i_clk,
  input wire        i_rst,
  input wire        i_psel,
  input wire        i_penable,
  input wire [31:0] o_prdata,
  input wire        o_pready,
  input wire        o_pslverr,
  input wire [12:0] i_actual_rpm,
  input wire        o_speed_pulse,
  input wire        o_power_enable,
  input wire        o_run_cw,
  input wire [12:0] o_speed_cmd
);
  reg [23:0] cyc; // Cycles since reset release; saturates, never wraps.

  // Counting from reset mirrors the power-on timer of the probe.
  always @(posedge i_clk)
  begin
    if (i_rst)
      cyc <= 24'h00_0000;
    else if (!cyc[23])
      cyc <= cyc + 24'h00_0001;
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  probe_rise_a: assert property ($rose(o_speed_pulse) &&
    cyc < P_PROBE_START_CYC + P_PROBE_PHASE_CYC |-> cyc >= P_PROBE_START_CYC
    && cyc <= P_PROBE_START_CYC + 2) else $error("probe rise off time");
  probe_low_a: assert property (cyc < P_PROBE_START_CYC |->
    !o_speed_pulse) else $error("pulse high before probe");
  probe_fall_a: assert property ($fell(o_speed_pulse) &&
    cyc < P_PROBE_START_CYC + 2 * P_PROBE_PHASE_CYC
    |-> cyc >= P_PROBE_START_CYC + P_PROBE_PHASE_CYC
    && cyc <= P_PROBE_START_CYC + P_PROBE_PHASE_CYC + 2)
    else $error("probe fall off time");
  power_wait_a: assert property (o_power_enable |->
    cyc > P_PROBE_START_CYC + 2 * P_PROBE_PHASE_CYC)
    else $error("power before probe end");
  ramp_step_a: assert property (o_power_enable &&
    $past(o_power_enable) && $past(o_power_enable, 2) && $changed(o_speed_cmd)
    |=> ($stable(o_speed_cmd) || !o_power_enable)[*8])
    else $error("speed command stepped too fast");
  coast_follow_a: assert property ((!o_power_enable &&
    $stable(i_actual_rpm))[*3] |-> o_speed_cmd == i_actual_rpm)
    else $error("command not tracking shaft");
  dir_swap_a: assert property ($changed(o_run_cw) |->
    !o_power_enable && $past(i_actual_rpm) <= 13'h00C8)
    else $error("direction swapped while driving");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  ready_cause_a: assert property ($rose(o_pready) |->
    $past(i_psel) && $past(i_penable)) else $error("ready without access");
  rdata_idle_a: assert property (!o_pready |-> o_prdata == 32'h0000_0000)
    else $error("read data outside ready");
  err_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");

  cover property ($rose(o_power_enable));
  cover property ($fell(o_run_cw));
  cover property (o_pslverr);
endmodule

bind msd_top msd_top_asserts #(.P_PROBE_START_CYC(P_PROBE_START_CYC),
  .P_PROBE_PHASE_CYC(P_PROBE_PHASE_CYC)) u_chk (.i_clk(i_clk),
  .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_actual_rpm(i_actual_rpm), .o_speed_pulse(o_speed_pulse),
  .o_power_enable(o_power_enable), .o_run_cw(o_run_cw),
  .o_speed_cmd(o_speed_cmd));

// file: dv/msd_top_test.sv
// Self-checking bench for the speed-command front end.
`timescale 1ns/10ps
module msd_top_test;
  localparam [22:0] ST = 23'h00_00C8; // Short probe start, 200 cycles.
  localparam [22:0] PH = 23'h00_0050; // Short probe phase, 80 cycles.
  logic        i_clk, i_rst, psel, penable, pwrite, en, dir, rerr;
  logic        o_pready, o_pslverr, o_speed_pulse, o_power_enable, o_run_cw;
  logic [7:0]  paddr;
  logic [31:0] pwdata, o_prdata, rdat;
  logic [13:0] amp, sv;
  logic [6:0]  duty;
  logic [12:0] rpm, o_speed_cmd;
  int          n_fail, num_checks, t0;
  int          cyc = 0; // Free-running cycle count for timing and timeout.
  logic        rst2, pulse2, pow2; // Second unit, pulse shorted to input.
  logic [12:0] cmd2;

  msd_sv_src u_src (.i_clk(i_clk), .i_amp_mv(amp), .i_duty_pct(duty),
    .o_setval_mv(sv));

  msd_top #(.P_PROBE_START_CYC(ST), .P_PROBE_PHASE_CYC(PH)) uut (
    .i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_enable_pin(en), .i_rotation_direction_select(dir),
    .i_setval_mv(sv), .i_supply_mv(15'h5DC0), .i_actual_rpm(rpm),
    .o_speed_pulse(o_speed_pulse), .o_power_enable(o_power_enable),
    .o_run_cw(o_run_cw), .o_speed_cmd(o_speed_cmd));

  // Second unit with its pulse pin shorted to its set-value input at 5 V,
  // made before power-on. Phases of 46000 cycles let the averaging filter
  // cross 2.5 V both ways, so this unit must pick two-wire mode.
  msd_top #(.P_PROBE_START_CYC(ST), .P_PROBE_PHASE_CYC(23'h00_B3B0)) uut2 (
    .i_clk(i_clk), .i_rst(rst2), .i_psel(1'b0), .i_penable(1'b0),
    .i_pwrite(1'b0), .i_paddr(8'h00), .i_pwdata(32'h0000_0000),
    .o_prdata(), .o_pready(), .o_pslverr(),
    .i_enable_pin(1'b0), .i_rotation_direction_select(1'b1),
    .i_setval_mv(pulse2 ? 14'h1388 : 14'h0000), .i_supply_mv(15'h5DC0),
    .i_actual_rpm(13'h176F), .o_speed_pulse(pulse2),
    .o_power_enable(pow2), .o_run_cw(), .o_speed_cmd(cmd2));

  initial
  begin
    i_clk = 0;
    forever #50 i_clk = ~i_clk;
  end

  task results();
  begin
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask

  // A hang must still end in the verdict, so the limit counts as a miss.
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 97000)
    begin
      n_fail++;
      results();
    end
  end

  task automatic chk(input string s, input [31:0] e, input [31:0] g);
  begin
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  end
  endtask

  // One APB transfer; the request holds until ready is sampled high.
  task automatic apb(input logic w, input [7:0] a, input [31:0] d);
    int n;
  begin
    n = 0;
    @(posedge i_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1;
    @(posedge i_clk);
    while (o_pready !== 1'b1 && n < 20)
    begin
      @(posedge i_clk);
      n++;
    end
    rdat = o_prdata;
    rerr = o_pslverr;
    psel <= 0;
    penable <= 0;
    chk("ready", 0, n == 20);
  end
  endtask

  // Waits, bounded, for the power stage to reach a level, then checks it.
  task automatic wpow(input logic v, input int lim);
    int n;
  begin
    n = 0;
    while (o_power_enable !== v && n < lim)
    begin
      @(posedge i_clk);
      n++;
    end
    chk("power", v, o_power_enable);
  end
  endtask

  task automatic wtog();
    logic p;
    int   n;
  begin
    p = o_speed_pulse;
    n = 0;
    while (o_speed_pulse === p && n < 9000)
    begin
      @(posedge i_clk);
      n++;
    end
  end
  endtask

  initial
  begin
    i_rst = 1;
    rst2 = 1;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    en = 1;
    dir = 1;
    amp = 0;
    duty = 100;
    rpm = 0;
    n_fail = 0;
    num_checks = 0;
    repeat (12) @(posedge i_clk);
    i_rst <= 0; // Shaft still, no short at power-on.
    rst2 <= 0; // The second unit powers up once and is never reset again.
    apb(0, 8'h00, 0);
    chk("ctrl", 32'h0000_0002, rdat);
    apb(0, 8'h04, 0);
    chk("status", 32'h0000_0008, rdat);
    apb(1, 8'h04, 32'hFFFF_FFFF);
    apb(0, 8'h20, 0);
    chk("unmapped", 1, rerr);
    chk("unmapped data", 0, rdat);
    repeat (400) @(posedge i_clk);
    apb(0, 8'h04, 0);
    chk("status", 32'h0000_0009, rdat);
    // Half duty of 4000 mV averages to 2000 mV, well inside the linear band.
    amp <= 14'h0FA0;
    duty <= 50;
    wpow(1, 20000);
    apb(0, 8'h08, 0);
    chk("setval", 1, rdat > 170 && rdat < 2000);
    en <= 0;
    wpow(0, 6);
    en <= 1;
    wpow(1, 6);
    apb(1, 8'h00, 32'h0000_0003);
    en <= 0;
    repeat (6) @(posedge i_clk);
    chk("dir version", 1, o_power_enable);
    dir <= 0;
    repeat (8) @(posedge i_clk);
    chk("direction", 0, o_run_cw);
    chk("power back", 1, o_power_enable);
    repeat (5000) @(posedge i_clk);
    chk("ramp", 1, o_speed_cmd >= 1 && o_speed_cmd <= 4);
    apb(1, 8'h00, 32'h0000_0002);
    dir <= 1;
    wpow(0, 6);
    rpm <= 13'h1770;
    repeat (4) @(posedge i_clk);
    chk("coast cmd", 32'h0000_1770, o_speed_cmd);
    apb(0, 8'h10, 0);
    chk("actual", 32'h0000_1770, rdat);
    // Stage is off here, so the monitor must still run.
    wtog();
    t0 = cyc;
    wtog();
    chk("pulse half", 1, cyc - t0 >= 8333 && cyc - t0 <= 8334);
    rpm <= 0;
    @(posedge i_clk);
    i_rst <= 1;
    repeat (3) @(posedge i_clk);
    i_rst <= 0;
    apb(0, 8'h04, 0);
    chk("status again", 32'h0000_0008, rdat);
    repeat (400) @(posedge i_clk);
    apb(0, 8'h04, 0);
    chk("rising input", 0, rdat[1]);
    // With enable low only two-wire mode can switch the shorted unit on.
    while (pow2 !== 1'b1 && cyc < 94000)
    begin
      @(posedge i_clk);
    end
    chk("two-wire power", 1, pow2);
    // Loaded at 5999 rpm, it must ramp to 24000 mV / 4 = 6000 rpm.
    repeat (1700) @(posedge i_clk);
    chk("two-wire speed", 32'h0000_1770, cmd2);
    results();
  end
endmodule
